// file: hdl/pulse_gen_pkg.sv
package pulse_gen_pkg;

	// timing: 4 ms control tick at the 250 MHz system clock
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TICK_MS = 4;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// pulses spent braking from f at rate r per tick is f*f/(DECEL_DIV*r)
	localparam int unsigned DECEL_DIV = 2 * 1000 / TICK_MS;
	localparam logic [31:0] NCO_WRAP = 32'(CLK_HZ / 2);
	localparam logic [31:0] MAX_FREQ_HZ = 32'h000F4240;

	// register byte offsets
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_PORT = 8'h04;
	localparam logic [7:0] OFF_MODE = 8'h08;
	localparam logic [7:0] OFF_RATE = 8'h0C;
	localparam logic [7:0] OFF_TARGET = 8'h10;
	localparam logic [7:0] OFF_COUNT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_FREQ0 = 8'h1C;
	localparam logic [7:0] OFF_FREQ1 = 8'h20;
	localparam logic [7:0] OFF_REMAIN0 = 8'h24;
	localparam logic [7:0] OFF_REMAIN1 = 8'h28;

	// command word fields and opcodes
	localparam int unsigned CMD_INTR_BIT = 8;
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_RAMP = 3'h1;
	localparam logic [2:0] OP_TRAP = 3'h2;
	localparam logic [2:0] OP_COUNT = 3'h3;
	localparam logic [2:0] OP_FIXED = 3'h4;
	localparam logic [2:0] OP_HALT = 3'h5;

	// mode, count and status fields
	localparam int unsigned MODE_IND_BIT = 0;
	localparam int unsigned MODE_DIR_BIT = 1;
	localparam int unsigned MODE_METHOD_BIT = 2;
	localparam int unsigned COUNT_ABS_BIT = 31;
	localparam int unsigned STAT_FAULT_BIT = 0;
	localparam logic [15:0] PORT_MAX = 16'h0001;

	// values after reset
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam logic [15:0] HALF_RST = 16'h0000;

	typedef enum logic [1:0] {PH_IDLE, PH_SLEW, PH_BRAKE} phase_type;

endpackage

// file: hdl/ramped_pulse_output_generator.sv
`timescale 1ns/1ps
`default_nettype none

module ramped_pulse_output_generator #(
	parameter int unsigned TICK_CYCLES = pulse_gen_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic run_mode,
	input wire logic [1:0] origin_known,
	input wire logic [1:0] home_active,
	output logic [1:0] cw_out,
	output logic [1:0] ccw_out,
	output logic fault_indicator
);

	localparam int unsigned TW = $clog2(TICK_CYCLES);

	// true once the remaining count is no more than the braking distance
	function automatic logic decel_due(input logic [31:0] rem, input logic [15:0] rate,
		input logic [31:0] f);
		logic [63:0] lhs;
		logic [63:0] rhs;
		lhs = 64'(rem) * 64'(rate) * 64'(pulse_gen_pkg::DECEL_DIV);
		rhs = 64'(f) * 64'(f);
		return lhs <= rhs;
	endfunction

	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic run_ok;
	logic [1:0] origin_ok;
	logic [1:0] home_busy;
	logic ph_wr_r;
	logic [7:0] ph_addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic [15:0] port_r;
	logic [15:0] mode_r;
	logic [15:0] rate_r;
	logic [31:0] target_r;
	logic [31:0] count_r;
	logic fault_r;
	logic [TW-1:0] tick_cnt_r;
	logic tick;
	pulse_gen_pkg::phase_type phase_r [2];
	logic [31:0] freq_r [2];
	logic [31:0] tgt_r [2];
	logic [15:0] crate_r [2];
	logic [31:0] remain_r [2];
	logic [31:0] pos_r [2];
	logic [31:0] pend_r [2];
	logic [31:0] acc_r [2];
	logic [32:0] sum_w [2];
	logic [1:0] dir_r;
	logic [1:0] ind_r;
	logic [1:0] meth_r;
	logic [1:0] fixst_r;
	logic [1:0] cyc_r;
	logic [1:0] loaded_r;
	logic [1:0] wave_r;
	logic [1:0] busy;
	logic [1:0] pulse_evt;
	logic [1:0] cw_r;
	logic [1:0] ccw_r;
	logic cmd_go;
	logic cmd_err;
	logic accept;
	logic [2:0] op;
	logic intr;
	logic sel;
	logic ind_new;
	logic range_bad;
	logic conflict;
	logic switch_bad;
	logic trap_zero;
	logic abs_bad;
	logic [31:0] src;
	logic [31:0] diff;
	logic st_dir;
	logic [31:0] st_remain;
	logic last_sel_r;

	// pins from outside the clock domain pass two flops first
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end else begin
			sync1_r <= {home_active, origin_known, run_mode};
			sync2_r <= sync1_r;
		end
	end
	assign run_ok = sync2_r[0];
	assign origin_ok = sync2_r[2:1];
	assign home_busy = sync2_r[4:3];

	// ahb address phase; zero wait states so hready is always our own
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ph_wr_r <= 1'b0;
			ph_addr_r <= 8'h00;
		end else if (hready) begin
			ph_wr_r <= hsel & htrans[1] & hwrite;
			ph_addr_r <= haddr[7:0];
		end
	end

	// read data captured at the address phase, stands in the data phase
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hrdata_r <= pulse_gen_pkg::WORD_RST;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_r <= rd_mux;
		end
	end

	always_comb begin
		case (haddr[7:0])
			pulse_gen_pkg::OFF_PORT: rd_mux = {16'h0000, port_r};
			pulse_gen_pkg::OFF_MODE: rd_mux = {16'h0000, mode_r};
			pulse_gen_pkg::OFF_RATE: rd_mux = {16'h0000, rate_r};
			pulse_gen_pkg::OFF_TARGET: rd_mux = target_r;
			pulse_gen_pkg::OFF_COUNT: rd_mux = count_r;
			pulse_gen_pkg::OFF_STATUS: rd_mux = {25'h0000000, ind_r, loaded_r, busy, fault_r};
			pulse_gen_pkg::OFF_FREQ0: rd_mux = freq_r[0];
			pulse_gen_pkg::OFF_FREQ1: rd_mux = freq_r[1];
			pulse_gen_pkg::OFF_REMAIN0: rd_mux = remain_r[0];
			pulse_gen_pkg::OFF_REMAIN1: rd_mux = remain_r[1];
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// setup words written in the data phase; a command sees them next cycle on
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			port_r <= pulse_gen_pkg::HALF_RST;
			mode_r <= pulse_gen_pkg::HALF_RST;
			rate_r <= pulse_gen_pkg::HALF_RST;
			target_r <= pulse_gen_pkg::WORD_RST;
			count_r <= pulse_gen_pkg::WORD_RST;
		end else if (ph_wr_r) begin
			case (ph_addr_r)
				pulse_gen_pkg::OFF_PORT: port_r <= hwdata[15:0];
				pulse_gen_pkg::OFF_MODE: mode_r <= hwdata[15:0];
				pulse_gen_pkg::OFF_RATE: rate_r <= hwdata[15:0];
				pulse_gen_pkg::OFF_TARGET: target_r <= hwdata;
				pulse_gen_pkg::OFF_COUNT: count_r <= hwdata;
				default: ;
			endcase
		end
	end

	// 4 ms control tick as a one-cycle enable
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_cnt_r <= '0;
		end else if (tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			busy[p] = (phase_r[p] != pulse_gen_pkg::PH_IDLE);
			sum_w[p] = {1'b0, acc_r[p]} + {1'b0, freq_r[p]};
			pulse_evt[p] = busy[p] & (sum_w[p] >= {1'b0, pulse_gen_pkg::NCO_WRAP}) & !wave_r[p];
		end
	end

	// command decode: each write to the command word is one request
	always_comb begin
		op = hwdata[2:0];
		intr = hwdata[pulse_gen_pkg::CMD_INTR_BIT];
		sel = port_r[0];
		ind_new = mode_r[pulse_gen_pkg::MODE_IND_BIT];
		cmd_go = ph_wr_r & (ph_addr_r == pulse_gen_pkg::OFF_COMMAND);
		range_bad = (port_r > pulse_gen_pkg::PORT_MAX) | (op == pulse_gen_pkg::OP_NONE)
			| (op > pulse_gen_pkg::OP_HALT) | (mode_r[15:3] != 13'h0000)
			| (target_r > pulse_gen_pkg::MAX_FREQ_HZ);
		conflict = (op != pulse_gen_pkg::OP_HALT)
			& (home_busy[sel] | (intr & busy[sel] & cyc_r[sel]));
		switch_bad = ((op == pulse_gen_pkg::OP_RAMP) | (op == pulse_gen_pkg::OP_FIXED))
			& busy[sel] & (ind_r[sel] != ind_new);
		trap_zero = (op == pulse_gen_pkg::OP_TRAP) & busy[sel] & !ind_r[sel]
			& (target_r == tgt_r[sel]) & (rate_r == 16'h0000);
		src = (op == pulse_gen_pkg::OP_TRAP) ? count_r : pend_r[sel];
		abs_bad = src[pulse_gen_pkg::COUNT_ABS_BIT] & !origin_ok[sel]
			& ((op == pulse_gen_pkg::OP_TRAP) | (((op == pulse_gen_pkg::OP_RAMP)
			| (op == pulse_gen_pkg::OP_FIXED)) & ind_new & !busy[sel] & loaded_r[sel]));
		cmd_err = cmd_go & (range_bad | conflict | switch_bad | trap_zero | abs_bad);
		accept = cmd_go & !cmd_err;
		// absolute target: 31-bit signed position, direction from the sign of travel
		diff = {src[30], src[30:0]} - pos_r[sel];
		if (src[pulse_gen_pkg::COUNT_ABS_BIT]) begin
			st_dir = diff[31];
			st_remain = diff[31] ? 32'(-diff) : diff;
		end else begin
			st_dir = mode_r[pulse_gen_pkg::MODE_DIR_BIT];
			st_remain = {1'b0, src[30:0]};
		end
	end

	// fault flag: sticky, write 1 to clear; a new fault in the same cycle wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fault_r <= 1'b0;
		end else if (cmd_err) begin
			fault_r <= 1'b1;
		end else if (ph_wr_r && ph_addr_r == pulse_gen_pkg::OFF_STATUS
			&& hwdata[pulse_gen_pkg::STAT_FAULT_BIT]) begin
			fault_r <= 1'b0;
		end
	end
	assign fault_indicator = fault_r;

	// per-channel profile state; commands are applied last so they override
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (!rst_b) begin
				phase_r[p] <= pulse_gen_pkg::PH_IDLE;
				freq_r[p] <= pulse_gen_pkg::WORD_RST;
				tgt_r[p] <= pulse_gen_pkg::WORD_RST;
				crate_r[p] <= pulse_gen_pkg::HALF_RST;
				remain_r[p] <= pulse_gen_pkg::WORD_RST;
				pos_r[p] <= pulse_gen_pkg::WORD_RST;
				pend_r[p] <= pulse_gen_pkg::WORD_RST;
				dir_r[p] <= 1'b0;
				ind_r[p] <= 1'b0;
				meth_r[p] <= 1'b0;
				fixst_r[p] <= 1'b0;
				cyc_r[p] <= 1'b0;
				loaded_r[p] <= 1'b0;
			end else if (!run_ok) begin
				phase_r[p] <= pulse_gen_pkg::PH_IDLE;
				freq_r[p] <= pulse_gen_pkg::WORD_RST;
				remain_r[p] <= pulse_gen_pkg::WORD_RST;
			end else begin
				if (pulse_evt[p]) begin
					pos_r[p] <= dir_r[p] ? pos_r[p] - 32'h00000001 : pos_r[p] + 32'h00000001;
					if (ind_r[p] && remain_r[p] != 32'h00000000) begin
						remain_r[p] <= remain_r[p] - 32'h00000001;
					end
				end
				if (busy[p] && ind_r[p] && remain_r[p] == 32'h00000000) begin
					phase_r[p] <= pulse_gen_pkg::PH_IDLE;
					freq_r[p] <= pulse_gen_pkg::WORD_RST;
				end else if (tick && busy[p]) begin
					case (phase_r[p])
						pulse_gen_pkg::PH_SLEW: begin
							// floor at one rate step so a short count still completes
							if (ind_r[p] && decel_due(remain_r[p], crate_r[p], freq_r[p])) begin
								freq_r[p] <= (freq_r[p] > {16'h0000, crate_r[p]})
									? freq_r[p] - {16'h0000, crate_r[p]} : {16'h0000, crate_r[p]};
							end else if (freq_r[p] < tgt_r[p]) begin
								freq_r[p] <= (tgt_r[p] - freq_r[p] > {16'h0000, crate_r[p]})
									? freq_r[p] + {16'h0000, crate_r[p]} : tgt_r[p];
							end else if (freq_r[p] > tgt_r[p]) begin
								freq_r[p] <= (freq_r[p] - tgt_r[p] > {16'h0000, crate_r[p]})
									? freq_r[p] - {16'h0000, crate_r[p]} : tgt_r[p];
							end
						end
						pulse_gen_pkg::PH_BRAKE: begin
							if (freq_r[p] <= {16'h0000, crate_r[p]}) begin
								phase_r[p] <= pulse_gen_pkg::PH_IDLE;
								freq_r[p] <= pulse_gen_pkg::WORD_RST;
								remain_r[p] <= pulse_gen_pkg::WORD_RST;
							end else begin
								freq_r[p] <= freq_r[p] - {16'h0000, crate_r[p]};
							end
						end
						default: ;
					endcase
				end
				if (accept && int'(sel) == p) begin
					case (op)
						pulse_gen_pkg::OP_COUNT: begin
							pend_r[p] <= count_r;
							loaded_r[p] <= 1'b1;
						end
						pulse_gen_pkg::OP_HALT: begin
							phase_r[p] <= pulse_gen_pkg::PH_IDLE;
							freq_r[p] <= pulse_gen_pkg::WORD_RST;
							remain_r[p] <= pulse_gen_pkg::WORD_RST;
							loaded_r[p] <= 1'b0;
						end
						pulse_gen_pkg::OP_FIXED: begin
							if (target_r == 32'h00000000) begin
								phase_r[p] <= pulse_gen_pkg::PH_IDLE;
								freq_r[p] <= pulse_gen_pkg::WORD_RST;
								remain_r[p] <= pulse_gen_pkg::WORD_RST;
							end else if (busy[p]) begin
								freq_r[p] <= target_r;
								tgt_r[p] <= target_r;
								fixst_r[p] <= 1'b1;
								phase_r[p] <= pulse_gen_pkg::PH_SLEW;
							end else if (!ind_new || loaded_r[p]) begin
								freq_r[p] <= target_r;
								tgt_r[p] <= target_r;
								phase_r[p] <= pulse_gen_pkg::PH_SLEW;
								ind_r[p] <= ind_new;
								meth_r[p] <= mode_r[pulse_gen_pkg::MODE_METHOD_BIT];
								dir_r[p] <= ind_new ? st_dir : mode_r[pulse_gen_pkg::MODE_DIR_BIT];
								remain_r[p] <= st_remain;
								loaded_r[p] <= 1'b0;
								fixst_r[p] <= 1'b1;
								cyc_r[p] <= !intr;
							end
						end
						pulse_gen_pkg::OP_RAMP: begin
							if (busy[p]) begin
								if (target_r == 32'h00000000) begin
									if (ind_r[p] && fixst_r[p]) begin
										phase_r[p] <= pulse_gen_pkg::PH_IDLE;
										freq_r[p] <= pulse_gen_pkg::WORD_RST;
										remain_r[p] <= pulse_gen_pkg::WORD_RST;
									end else begin
										phase_r[p] <= pulse_gen_pkg::PH_BRAKE;
									end
								end else begin
									crate_r[p] <= rate_r;
									tgt_r[p] <= target_r;
									phase_r[p] <= pulse_gen_pkg::PH_SLEW;
								end
							end else if (target_r != 32'h00000000 && (!ind_new || loaded_r[p])) begin
								freq_r[p] <= pulse_gen_pkg::WORD_RST;
								crate_r[p] <= rate_r;
								tgt_r[p] <= target_r;
								phase_r[p] <= pulse_gen_pkg::PH_SLEW;
								ind_r[p] <= ind_new;
								meth_r[p] <= mode_r[pulse_gen_pkg::MODE_METHOD_BIT];
								dir_r[p] <= ind_new ? st_dir : mode_r[pulse_gen_pkg::MODE_DIR_BIT];
								remain_r[p] <= st_remain;
								loaded_r[p] <= 1'b0;
								fixst_r[p] <= 1'b0;
								cyc_r[p] <= !intr;
							end
						end
						pulse_gen_pkg::OP_TRAP: begin
							crate_r[p] <= rate_r;
							tgt_r[p] <= target_r;
							ind_r[p] <= 1'b1;
							remain_r[p] <= st_remain;
							dir_r[p] <= st_dir;
							phase_r[p] <= pulse_gen_pkg::PH_SLEW;
							cyc_r[p] <= !intr;
							if (!busy[p]) begin
								freq_r[p] <= pulse_gen_pkg::WORD_RST;
								meth_r[p] <= mode_r[pulse_gen_pkg::MODE_METHOD_BIT];
								fixst_r[p] <= 1'b0;
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// phase accumulator: wave toggles each time half a clock-rate of Hz accrues
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (!rst_b) begin
				acc_r[p] <= pulse_gen_pkg::WORD_RST;
				wave_r[p] <= 1'b0;
			end else if (busy[p] && run_ok) begin
				if (sum_w[p] >= {1'b0, pulse_gen_pkg::NCO_WRAP}) begin
					acc_r[p] <= 32'(sum_w[p] - {1'b0, pulse_gen_pkg::NCO_WRAP});
					wave_r[p] <= ~wave_r[p];
				end else begin
					acc_r[p] <= sum_w[p][31:0];
				end
			end else begin
				acc_r[p] <= pulse_gen_pkg::WORD_RST;
				wave_r[p] <= 1'b0;
			end
		end
	end

	// pin shaping: cw/ccw pair, or pulse plus direction level on ccw
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (!rst_b) begin
				cw_r[p] <= 1'b0;
				ccw_r[p] <= 1'b0;
			end else if (meth_r[p]) begin
				cw_r[p] <= wave_r[p];
				ccw_r[p] <= dir_r[p];
			end else begin
				cw_r[p] <= wave_r[p] & !dir_r[p];
				ccw_r[p] <= wave_r[p] & dir_r[p];
			end
		end
	end
	assign cw_out = cw_r;
	assign ccw_out = ccw_r;

	// helper for checks: channel that port_r selected one cycle earlier
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_sel_r <= 1'b0;
		end else begin
			last_sel_r <= sel;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_port_route: assert property (accept && op == pulse_gen_pkg::OP_FIXED
		&& target_r != 32'h00000000 && !ind_new && run_ok |=> busy[last_sel_r])
		else $error("fixed speed start did not reach the selected channel");
	chk_port_range: assert property (cmd_go && port_r > pulse_gen_pkg::PORT_MAX
		|=> fault_r && (busy & ~$past(busy)) == 2'b00)
		else $error("out of range port was not refused");
	chk_slew_step: assert property (tick && phase_r[0] == pulse_gen_pkg::PH_SLEW
		&& !ind_r[0] && run_ok && !cmd_go
		&& ({1'b0, freq_r[0]} + {17'h00000, crate_r[0]}) <= {1'b0, tgt_r[0]}
		|=> freq_r[0] == $past(freq_r[0]) + {16'h0000, $past(crate_r[0])})
		else $error("tick step differs from the programmed rate");
	chk_count_stop: assert property (busy[0] && ind_r[0] && remain_r[0] == 32'h00000000
		&& !cmd_go |=> !busy[0] ##1 !wave_r[0])
		else $error("count-limited output ran past its count");
	chk_free_run: assert property (busy[0] && !ind_r[0] && phase_r[0] == pulse_gen_pkg::PH_SLEW
		&& run_ok && !cmd_go |=> busy[0])
		else $error("free-running output stopped by itself");
	chk_mode_switch: assert property (cmd_go && op == pulse_gen_pkg::OP_RAMP
		&& busy[sel] && ind_r[sel] != ind_new |=> fault_r && ind_r == $past(ind_r))
		else $error("mode switch on a busy port was accepted");
	chk_trap_zero: assert property (cmd_go && trap_zero
		|=> fault_r && ind_r == $past(ind_r) && tgt_r[last_sel_r] == $past(target_r))
		else $error("zero rate trapezoid on free run was accepted");
	chk_run_stop: assert property (!run_ok |=> busy == 2'b00 ##1 wave_r == 2'b00)
		else $error("pulses continued outside run state");
	chk_halt_clear: assert property (accept && op == pulse_gen_pkg::OP_HALT && !sel
		|=> !busy[0] && remain_r[0] == 32'h00000000 && !loaded_r[0])
		else $error("halt left count or output behind");
	chk_fixed_zero: assert property (accept && op == pulse_gen_pkg::OP_FIXED
		&& target_r == 32'h00000000 && !sel |=> !busy[0] && freq_r[0] == 32'h00000000)
		else $error("zero fixed speed did not stop at once");
	chk_brake_rate: assert property (tick && phase_r[0] == pulse_gen_pkg::PH_BRAKE
		&& freq_r[0] > {16'h0000, crate_r[0]} && run_ok && !cmd_go
		&& !(ind_r[0] && remain_r[0] == 32'h00000000)
		|=> freq_r[0] == $past(freq_r[0]) - {16'h0000, $past(crate_r[0])})
		else $error("braking used a rate other than the one in force");

	cov_trap_on_free: cover property (accept && op == pulse_gen_pkg::OP_TRAP && busy[sel] && !ind_r[sel]);
	cov_brake_done: cover property (phase_r[0] == pulse_gen_pkg::PH_BRAKE ##1 !busy[0]);
	cov_count_done: cover property (busy[0] && ind_r[0] ##1 !busy[0]);

endmodule // ramped_pulse_output_generator

`default_nettype wire

// file: test/pulse_driver_model.sv
`timescale 1ns/1ps
`default_nettype none

// motor driver step inputs: one step per rising edge on each line
module pulse_driver_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] cw_out,
	input wire logic [1:0] ccw_out,
	output logic [1:0][15:0] fwd_cnt,
	output logic [1:0][15:0] rev_cnt
);
	logic [1:0] cw_r;
	logic [1:0] ccw_r;

	// both channels run cw/ccw, so line b carries reverse steps, never a level
	always_ff @(posedge clk) begin
		cw_r <= cw_out;
		ccw_r <= ccw_out;
		for (int i = 0; i < 2; i++) begin
			if (!rst_b) begin
				fwd_cnt[i] <= 16'h0000;
				rev_cnt[i] <= 16'h0000;
			end else begin
				if (cw_out[i] && !cw_r[i]) fwd_cnt[i] <= fwd_cnt[i] + 16'h0001;
				if (ccw_out[i] && !ccw_r[i]) rev_cnt[i] <= rev_cnt[i] + 16'h0001;
			end
		end
	end
endmodule // pulse_driver_model

`default_nettype wire

// file: test/tb_ramped_pulse_output_generator.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ramped_pulse_output_generator;
	localparam int unsigned TICK = 50;
	localparam logic [31:0] RATE = 32'h0000C350;
	localparam logic [31:0] F200K = 32'h00030D40;
	logic clk, rst_b, hsel, hwrite, run_mode, hreadyout, hresp, fault_indicator;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans, origin_known, home_active, cw_out, ccw_out;
	logic [2:0] hsize;
	logic [1:0][15:0] fwd_cnt, rev_cnt;
	logic [15:0] snap;
	int mismatches, cmp_count, cycles;

	// short tick keeps the ramps to a few hundred clocks
	ramped_pulse_output_generator #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .rst_b(rst_b),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .run_mode(run_mode), .origin_known(origin_known),
		.home_active(home_active), .cw_out(cw_out), .ccw_out(ccw_out),
		.fault_indicator(fault_indicator));
	pulse_driver_model u_drv (.clk(clk), .rst_b(rst_b), .cw_out(cw_out), .ccw_out(ccw_out),
		.fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt));

	task automatic final_report;
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; read data lands in v at the data-phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		v = hrdata;
	endtask

	task automatic rd(input logic [7:0] a);
		ahb(1'b0, a, 32'h00000000);
	endtask

	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge clk);
	endtask

	task automatic go(input logic [15:0] p, input logic [15:0] m, input logic [31:0] r,
		input logic [31:0] t, input logic [2:0] op);
		ahb(1'b1, pulse_gen_pkg::OFF_PORT, {16'h0000, p});
		ahb(1'b1, pulse_gen_pkg::OFF_MODE, {16'h0000, m});
		ahb(1'b1, pulse_gen_pkg::OFF_RATE, r);
		ahb(1'b1, pulse_gen_pkg::OFF_TARGET, t);
		ahb(1'b1, pulse_gen_pkg::OFF_COMMAND, {29'h00000000, op});
	endtask

	// bounded poll until channel 0 frequency leaves a known value
	task automatic poll(input logic [31:0] old);
		int n;
		n = 0;
		v = old;
		while (v === old && n < 200) begin
			rd(pulse_gen_pkg::OFF_FREQ0);
			n++;
		end
	endtask

	// bounded poll of the status word until the busy bits in m clear
	task automatic wait_idle(input logic [31:0] m);
		int n;
		n = 0;
		v = m;
		while ((v & m) !== 32'h00000000 && n < 15000) begin
			rd(pulse_gen_pkg::OFF_STATUS);
			n++;
		end
	endtask

	task automatic fcase(input logic [15:0] p, input logic [15:0] m, input logic [31:0] t,
		input logic [2:0] op);
		go(p, m, RATE, t, op);
		rd(pulse_gen_pkg::OFF_STATUS);
		chk({31'h00000000, hresp}, 32'h00000000);
		chk(v & 32'h00000001, 32'h00000001);
		chk({31'h00000000, fault_indicator}, 32'h00000001);
		ahb(1'b1, pulse_gen_pkg::OFF_STATUS, 32'h00000001);
		rd(pulse_gen_pkg::OFF_STATUS);
		chk(v & 32'h00000001, 32'h00000000);
	endtask

	task automatic t_faults;
		rd(8'h40);
		chk(v, 32'h00000000);
		fcase(16'h0002, 16'h0000, F200K, pulse_gen_pkg::OP_RAMP);
		fcase(16'h0000, 16'h0000, F200K, pulse_gen_pkg::OP_NONE);
		fcase(16'h0000, 16'h0008, F200K, pulse_gen_pkg::OP_RAMP);
		fcase(16'h0000, 16'h0000, 32'h000F4241, pulse_gen_pkg::OP_RAMP);
		// absolute count while the origin is unknown
		ahb(1'b1, pulse_gen_pkg::OFF_COUNT, 32'h80000005);
		origin_known <= 2'b00;
		fcase(16'h0000, 16'h0001, F200K, pulse_gen_pkg::OP_TRAP);
		origin_known <= 2'b11;
		home_active <= 2'b10;
		fcase(16'h0001, 16'h0000, F200K, pulse_gen_pkg::OP_RAMP);
		home_active <= 2'b00;
	endtask

	task automatic t_free;
		go(16'h0000, 16'h0000, RATE, F200K, pulse_gen_pkg::OP_RAMP);
		poll(32'h00000000);
		chk(v, RATE);
		go(16'h0000, 16'h0000, 32'h000061A8, F200K, pulse_gen_pkg::OP_RAMP);
		poll(RATE);
		chk(v, 32'h000124F8);
		ticks(10);
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, F200K);
		ticks(30);
		chk({31'h00000000, fwd_cnt[0] != 16'h0000}, 32'h00000001);
		chk({16'h0000, fwd_cnt[1] | rev_cnt[0] | rev_cnt[1]}, 32'h00000000);
		go(16'h0000, 16'h0000, RATE, 32'h000186A0, pulse_gen_pkg::OP_RAMP);
		poll(F200K);
		chk(v, 32'h000249F0);
		ticks(3);
		// a new rate of 1 must be ignored on the way down to zero
		go(16'h0000, 16'h0000, 32'h00000001, 32'h00000000, pulse_gen_pkg::OP_RAMP);
		poll(32'h000186A0);
		chk(v, RATE);
		ticks(3);
		rd(pulse_gen_pkg::OFF_STATUS);
		chk(v & 32'h00000006, 32'h00000000);
	endtask

	task automatic t_stop;
		go(16'h0000, 16'h0000, RATE, F200K, pulse_gen_pkg::OP_FIXED);
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, F200K);
		ahb(1'b1, pulse_gen_pkg::OFF_COUNT, 32'h0000000A);
		go(16'h0000, 16'h0001, RATE, F200K, pulse_gen_pkg::OP_COUNT);
		fcase(16'h0000, 16'h0001, F200K, pulse_gen_pkg::OP_RAMP);
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, F200K);
		go(16'h0000, 16'h0000, RATE, 32'h00000000, pulse_gen_pkg::OP_FIXED);
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, 32'h00000000);
		go(16'h0000, 16'h0000, RATE, F200K, pulse_gen_pkg::OP_RAMP);
		ticks(6);
		ahb(1'b1, pulse_gen_pkg::OFF_COMMAND, {29'h00000000, pulse_gen_pkg::OP_HALT});
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, 32'h00000000);
		// pins trail the internal wave, so let a last edge settle first
		repeat (4) @(posedge clk);
		snap = fwd_cnt[0];
		repeat (400) @(posedge clk);
		chk({16'h0000, fwd_cnt[0]}, {16'h0000, snap});
	endtask

	task automatic t_count;
		snap = fwd_cnt[0];
		go(16'h0000, 16'h0001, RATE, 32'h000F4240, pulse_gen_pkg::OP_RAMP);
		ticks(4);
		chk({16'h0000, fwd_cnt[0]}, {16'h0000, snap});
		// four steps cannot reach 1 MHz, so the profile turns after its first rate step
		ahb(1'b1, pulse_gen_pkg::OFF_COUNT, 32'h00000004);
		go(16'h0000, 16'h0001, RATE, 32'h000F4240, pulse_gen_pkg::OP_COUNT);
		go(16'h0000, 16'h0001, RATE, 32'h000F4240, pulse_gen_pkg::OP_RAMP);
		wait_idle(32'h00000002);
		repeat (10) @(posedge clk);
		chk({16'h0000, fwd_cnt[0] - snap}, 32'h00000004);
		chk(v & 32'h00000001, 32'h00000000);
		rd(pulse_gen_pkg::OFF_REMAIN0);
		chk(v, 32'h00000000);
		ahb(1'b1, pulse_gen_pkg::OFF_COUNT, 32'h000003E8);
		go(16'h0000, 16'h0001, RATE, 32'h000F4240, pulse_gen_pkg::OP_COUNT);
		go(16'h0000, 16'h0001, RATE, 32'h000F4240, pulse_gen_pkg::OP_RAMP);
		ticks(2);
		ahb(1'b1, pulse_gen_pkg::OFF_COMMAND, {29'h00000000, pulse_gen_pkg::OP_HALT});
		rd(pulse_gen_pkg::OFF_REMAIN0);
		chk(v, 32'h00000000);
	endtask

	// fixed 50 kHz reverse run on channel 1, then a trapezoid turns it into a 3 step feed;
	// the first wave edge is 2500 clocks out, so no step slips in before the feed starts
	task automatic t_trap;
		go(16'h0001, 16'h0002, RATE, RATE, pulse_gen_pkg::OP_FIXED);
		go(16'h0001, 16'h0002, 32'h00000000, RATE, pulse_gen_pkg::OP_TRAP);
		rd(pulse_gen_pkg::OFF_STATUS);
		chk(v & 32'h00000007, 32'h00000005);
		ahb(1'b1, pulse_gen_pkg::OFF_STATUS, 32'h00000001);
		ahb(1'b1, pulse_gen_pkg::OFF_COUNT, 32'h00000003);
		go(16'h0001, 16'h0002, RATE, RATE, pulse_gen_pkg::OP_TRAP);
		rd(pulse_gen_pkg::OFF_REMAIN1);
		chk(v, 32'h00000003);
		// ramp from an interrupt task while the cyclic trapezoid runs
		ahb(1'b1, pulse_gen_pkg::OFF_COMMAND, 32'h00000101);
		rd(pulse_gen_pkg::OFF_STATUS);
		chk(v & 32'h00000005, 32'h00000005);
		ahb(1'b1, pulse_gen_pkg::OFF_STATUS, 32'h00000001);
		wait_idle(32'h00000004);
		repeat (10) @(posedge clk);
		chk({16'h0000, rev_cnt[1]}, 32'h00000003);
		chk({16'h0000, fwd_cnt[1]}, 32'h00000000);
	endtask

	task automatic t_run;
		go(16'h0000, 16'h0000, RATE, F200K, pulse_gen_pkg::OP_RAMP);
		ticks(6);
		run_mode <= 1'b0;
		repeat (8) @(posedge clk);
		rd(pulse_gen_pkg::OFF_FREQ0);
		chk(v, 32'h00000000);
		snap = fwd_cnt[0];
		repeat (600) @(posedge clk);
		chk({16'h0000, fwd_cnt[0]}, {16'h0000, snap});
		run_mode <= 1'b1;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard, well above the roughly 35k clocks the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		{rst_b, hsel, hwrite, htrans, haddr, hwdata, home_active} = '0;
		hsize = 3'b010;
		run_mode = 1'b1;
		origin_known = 2'b11;
		{mismatches, cmp_count, cycles} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_faults();
		t_free();
		t_stop();
		t_count();
		t_trap();
		t_run();
		final_report();
	end
endmodule // tb_ramped_pulse_output_generator

`default_nettype wire
